// ===== tb_top.sv
// Purpose: self-checking bench for the timer mode and control registers
// Assumes: AXI4-Lite master in the bench, decoded outputs lag one cycle
// Notes:   register model and decode model are kept in the bench
`timescale 1ns/1ps
module tb_top
	import tmc_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, joined, ia, ib, ta, tb, sa, sb;
	logic        ena, enb, cc;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, ea, eb, r;
	tmc_fn_t     fa, fb;
	integer      mismatches, checked, seed, cyc, i, g, m;
	logic [31:0] m_reg [4];
	localparam logic [31:0] MASKS [4] = '{TMC_GLOBAL_MASK, TMC_MODE_MASK, TMC_MODE_MASK,
		TMC_CTRL_MASK};

	tmc_regs i_tmc_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .joined_32(joined), .half_a_function(fa),
		.half_b_function(fb), .half_a_edge_select(ea), .half_b_edge_select(eb),
		.half_a_output_invert(ia), .half_b_output_invert(ib), .half_a_trigger_enable(ta),
		.half_b_trigger_enable(tb), .half_a_stall_enable(sa), .half_b_stall_enable(sb),
		.half_a_enable(ena), .half_b_enable(enb), .clock_count_enable(cc));

	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic note(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// bus results and decoded results share one report path
	task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
		note(got, exp);
	endtask
	task automatic cmp_dec(input logic [31:0] got, input logic [31:0] exp);
		note(got, exp);
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
		output logic [1:0] rsp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// register write with model update per byte lane
	task automatic wreg(input integer n, input logic [31:0] v, input logic [3:0] s);
		logic [1:0] rsp;
		wr(12'(n * 4), v, s, rsp);
		cmp_bus(32'(rsp), 32'(TMC_RESP_OKAY));
		for (int k = 0; k < 4; k++)
			if (s[k])
				m_reg[n][k*8+:8] = v[k*8+:8] & MASKS[n][k*8+:8];
	endtask

	task automatic rreg(input integer n);
		logic [31:0] v;
		logic [1:0]  rsp;
		rd(12'(n * 4), v, rsp);
		cmp_bus(v, m_reg[n]);
		cmp_bus(32'(rsp), 32'(TMC_RESP_OKAY));
	endtask

	// decode model: mode word first, then the global field keeps what is legal
	function automatic tmc_fn_t exp_fn(input logic [31:0] gc, input logic [31:0] mc);
		tmc_fn_t f;
		case (mc[1:0])
			2'h1: f = TMC_FN_ONESHOT;
			2'h2: f = TMC_FN_PERIODIC;
			2'h3: f = mc[2] ? TMC_FN_EDGE_TIME : TMC_FN_EDGE_COUNT;
			default: f = TMC_FN_OFF;
		endcase
		if (mc[3])
			f = (mc[2:0] == 3'h2) ? TMC_FN_PWM : TMC_FN_OFF;
		if (gc == 1)
			return TMC_FN_RTC;
		if (gc == 0 && f != TMC_FN_ONESHOT && f != TMC_FN_PERIODIC)
			return TMC_FN_OFF;
		return f;
	endfunction

	task automatic check_dec();
		logic [31:0] c;
		tmc_fn_t     xa, xb;
		c = m_reg[3];
		xa = exp_fn(m_reg[0], m_reg[1]);
		xb = (m_reg[0] > 3) ? exp_fn(m_reg[0], m_reg[2]) : TMC_FN_OFF;
		repeat (2) @(posedge aclk);
		cmp_dec(32'({joined, fa, ea, ia, ta, sa, ena, cc}), 32'({m_reg[0] < 4, xa,
			(c[3:2] == 2'h2) ? 2'h0 : c[3:2], c[6], c[5], c[1], c[0] && xa != TMC_FN_OFF,
			c[4] && m_reg[0] == 1}));
		cmp_dec(32'({fb, eb, ib, tb, sb, enb}), 32'({xb,
			(c[11:10] == 2'h2) ? 2'h0 : c[11:10], c[14], c[13], c[9],
			c[8] && xb != TMC_FN_OFF}));
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		m_reg = '{default: 32'h0};
		for (int n = 0; n < 4; n++)
			rreg(n);
		check_dec();
	endtask

	// main sequence
	initial begin
		seed = 61;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		do_reset();
		wr(12'h010, 32'hffff_ffff, 4'hf, r);
		cmp_bus(32'(r), 32'(TMC_RESP_SLVERR));
		rd(12'h010, d, r);
		cmp_bus(d, 32'h0);
		cmp_bus(32'(r), 32'(TMC_RESP_SLVERR));
		for (i = 0; i < 4; i++) begin
			wreg(i, 32'hffff_ffff, 4'hf);
			rreg(i);
		end
		wreg(3, 32'h0, 4'hf);
		wreg(3, $random(seed), 4'h2);
		rreg(3);
		for (g = 0; g < 8; g++) begin
			for (m = 0; m < 16; m++) begin
				if (g == 2 || g == 3)
					continue;
				wreg(3, 32'h0, 4'hf);
				wreg(0, g, 4'hf);
				wreg(1, m, 4'hf);
				wreg(2, $random(seed) & 32'hf, 4'hf);
				wreg(3, $random(seed), 4'hf);
				rreg(3);
				check_dec();
			end
		end
		do_reset();
		end_of_test();
	end
endmodule // tb_top

// ===== tmc_pkg.sv
// Purpose: constants for the timer mode and control register block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   offsets are byte addresses
package tmc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] TMC_OFS_GLOBAL = 12'h000;
	localparam logic [11:0] TMC_OFS_A_MODE = 12'h004;
	localparam logic [11:0] TMC_OFS_B_MODE = 12'h008;
	localparam logic [11:0] TMC_OFS_CTRL   = 12'h00c;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] TMC_GLOBAL_MASK = 32'h0000_0007;
	localparam logic [31:0] TMC_MODE_MASK   = 32'h0000_000f;
	localparam logic [31:0] TMC_CTRL_MASK   = 32'h0000_6f7f;
	localparam logic [31:0] TMC_RESET_VAL   = 32'h0000_0000;
	localparam int TMC_B_SHIFT     = 8;   // half B control fields sit 8 bits above A
	localparam int TMC_BIT_ENABLE  = 0;
	localparam int TMC_BIT_STALL   = 1;
	localparam int TMC_BIT_EDGE_LO = 2;
	localparam int TMC_BIT_RTC_EN  = 4;
	localparam int TMC_BIT_TRIG    = 5;
	localparam int TMC_BIT_INVERT  = 6;
	localparam int TMC_BIT_ALT     = 3;
	localparam int TMC_BIT_CAPTYPE = 2;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] TMC_CFG_JOINED = 3'h0;
	localparam logic [2:0] TMC_CFG_RTC    = 3'h1;
	localparam logic [1:0] TMC_MF_ONESHOT = 2'h1;
	localparam logic [1:0] TMC_MF_PERIOD  = 2'h2;
	localparam logic [1:0] TMC_MF_CAPTURE = 2'h3;
	localparam logic [1:0] TMC_EDGE_RESV  = 2'h2;
	localparam logic [1:0] TMC_RESP_OKAY  = 2'h0;
	localparam logic [1:0] TMC_RESP_SLVERR = 2'h2;

	// decoded function of one half
	typedef enum logic [2:0] {
		TMC_FN_OFF,
		TMC_FN_ONESHOT,
		TMC_FN_PERIODIC,
		TMC_FN_EDGE_COUNT,
		TMC_FN_EDGE_TIME,
		TMC_FN_PWM,
		TMC_FN_RTC
	} tmc_fn_t;

endpackage

// ===== tmc_regs.sv
// Purpose: mode and control registers of a dual 16-bit / joined 32-bit timer
// Assumes: one clock, AXI4-Lite slave, counting datapath lives elsewhere
// Notes:   decoded function and gated controls are registered outputs
//          a write lands one edge after both beats are taken, bvalid shows then
//          read data answers at the same edge that takes the address
//          reserved global codes and malformed mode words leave a half idle
//          decoded outputs follow a register change one edge later
//
// Function
// - global field 0 joins both halves as one 32-bit periodic/one-shot timer
// - global field 1 runs the joined 32-bit counter as real-time clock
// - global values 4..7 split into two 16-bit timers, each by its mode
// - mode field 1 one-shot, 2 periodic, 3 capture, 0 reserved
// - alternate bit 3: zero capture, one PWM
// - capture type bit 2: zero counts edges, one timestamps edges
// - in 32-bit configurations only half A mode register counts
// - in 16-bit configuration each mode register controls its own half
// - edge select 00 rising, 01 falling, 11 both, 10 reserved
// - output-level bit inverts that half's PWM output
// - trigger enable gates that half's trigger output
// - stall enable permits the half to stall when set
// - enable bit starts counting or capture; clearing disables the half
// - control bit 4 enables real-time clock counting
// - reserved bits read unspecified; software preserves them
// - all configuration, mode and control fields reset to zero
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps

module tmc_regs
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address and data
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address and data
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// decoded configuration towards the counting datapath
	output logic             joined_32,
	output tmc_fn_t          half_a_function,
	output tmc_fn_t          half_b_function,
	output logic [1:0]       half_a_edge_select,
	output logic [1:0]       half_b_edge_select,
	output logic             half_a_output_invert,
	output logic             half_b_output_invert,
	output logic             half_a_trigger_enable,
	output logic             half_b_trigger_enable,
	output logic             half_a_stall_enable,
	output logic             half_b_stall_enable,
	output logic             half_a_enable,
	output logic             half_b_enable,
	output logic             clock_count_enable
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// apply byte strobes, then drop reserved bits so they never store
	// a blind read-modify-write by software can then never plant a reserved bit
	function automatic logic [31:0] merge_word(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb,
			input logic [31:0] mask);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	// mode nibble to function of one half
	function automatic tmc_fn_t decode_mode(input logic [3:0] m);
		tmc_fn_t fn;
		fn = TMC_FN_OFF;
		if (m[TMC_BIT_ALT]) begin
			// PWM needs edge-count and periodic alongside the alternate bit
			if (!m[TMC_BIT_CAPTYPE] && m[1:0] == TMC_MF_PERIOD) begin
				fn = TMC_FN_PWM;
			end
		end else begin
			// alternate bit clear: the low two bits pick timer or capture mode
			case (m[1:0])
				TMC_MF_ONESHOT: fn = TMC_FN_ONESHOT;
				TMC_MF_PERIOD: fn = TMC_FN_PERIODIC;
				TMC_MF_CAPTURE: fn = m[TMC_BIT_CAPTYPE] ? TMC_FN_EDGE_TIME
					: TMC_FN_EDGE_COUNT;
				default: fn = TMC_FN_OFF; // reserved mode leaves the half idle
			endcase
		end
		return fn;
	endfunction

	// edge select with the reserved code falling back to rising edge
	// the datapath never sees the reserved code, at the cost of hiding a bad write
	function automatic logic [1:0] clean_edge(input logic [1:0] e);
		return (e == TMC_EDGE_RESV) ? 2'h0 : e;
	endfunction

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	// full words are kept; the masks hold reserved positions at zero
	logic [31:0] global_q, global_d;
	logic [31:0] a_mode_q, a_mode_d;
	logic [31:0] b_mode_q, b_mode_d;
	logic [31:0] ctrl_q,   ctrl_d;

	// ----------------------------------------------------------------
	// bus handshake state
	// ----------------------------------------------------------------
	logic        aw_held_q, aw_held_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        w_held_q,  w_held_d;
	logic [31:0] w_data_q,  w_data_d;
	logic [3:0]  w_strb_q,  w_strb_d;
	logic        bvalid_q,  bvalid_d;
	logic [1:0]  bresp_q,   bresp_d;
	logic        rvalid_q,  rvalid_d;
	logic [31:0] rdata_q,   rdata_d;
	logic [1:0]  rresp_q,   rresp_d;
	logic        awready_q, awready_d;
	logic        wready_q,  wready_d;
	logic        arready_q, arready_d;
	// marks the cycle in which a held address and data pair commits
	logic        do_write;

	// write path: address and data latch separately, commit once both held
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		global_d  = global_q;
		a_mode_d  = a_mode_q;
		b_mode_d  = b_mode_q;
		ctrl_d    = ctrl_q;
		do_write  = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		// commit waits for a free response slot, so a held pair never loses its answer
		if (aw_held_q && w_held_q && !bvalid_q) begin
			do_write  = 1'b1;
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = TMC_RESP_OKAY;
			case (aw_addr_q)
				TMC_OFS_GLOBAL: global_d = merge_word(global_q, w_data_q, w_strb_q,
					TMC_GLOBAL_MASK);
				TMC_OFS_A_MODE: a_mode_d = merge_word(a_mode_q, w_data_q, w_strb_q,
					TMC_MODE_MASK);
				TMC_OFS_B_MODE: b_mode_d = merge_word(b_mode_q, w_data_q, w_strb_q,
					TMC_MODE_MASK);
				TMC_OFS_CTRL: ctrl_d = merge_word(ctrl_q, w_data_q, w_strb_q,
					TMC_CTRL_MASK);
				default: bresp_d = TMC_RESP_SLVERR; // unmapped: nothing stored
			endcase
		end
		// the response leaves at the edge where the master takes it
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// ready is low while a beat is held, so each channel takes one item at a time
	always_comb begin
		awready_d = !aw_held_d && !do_write;
		wready_d  = !w_held_d && !do_write;
	end

	// read path: one outstanding read, answered the cycle after acceptance
	always_comb begin
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		arready_d = arready_q;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = TMC_RESP_OKAY;
			// data is taken at acceptance; a write committing at that edge shows next read
			case (s_axi_araddr)
				TMC_OFS_GLOBAL: rdata_d = global_q; // reserved bits stay zero
				TMC_OFS_A_MODE: rdata_d = a_mode_q;
				TMC_OFS_B_MODE: rdata_d = b_mode_q;
				TMC_OFS_CTRL:   rdata_d = ctrl_q;
				default: begin
					rdata_d = TMC_RESET_VAL;
					rresp_d = TMC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end else if (!rvalid_q && !arready_q) begin
			// first edge out of reset: open the read address channel
			arready_d = 1'b1;
		end
	end

	// bus and register flops; everything clears to zero on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_q  <= TMC_RESET_VAL;
			a_mode_q  <= TMC_RESET_VAL;
			b_mode_q  <= TMC_RESET_VAL;
			ctrl_q    <= TMC_RESET_VAL;
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= TMC_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= TMC_RESP_OKAY;
			// readys stay low in reset and rise one edge after it is released
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			global_q  <= global_d;
			a_mode_q  <= a_mode_d;
			b_mode_q  <= b_mode_d;
			ctrl_q    <= ctrl_d;
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
		end
	end

	// ----------------------------------------------------------------
	// bus outputs
	// ----------------------------------------------------------------
	// every bus output is a flop, so no input reaches an output in the same cycle
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	logic        joined_q,  joined_d;
	tmc_fn_t     fn_a_q,    fn_a_d;
	tmc_fn_t     fn_b_q,    fn_b_d;
	logic [1:0]  edge_a_q,  edge_a_d;
	logic [1:0]  edge_b_q,  edge_b_d;
	logic [5:0]  flags_q,   flags_d;   // inv a/b, trig a/b, stall a/b
	logic [2:0]  en_q,      en_d;      // en a, en b, rtc
	tmc_fn_t     fn_a_raw;
	tmc_fn_t     fn_b_raw;
	logic [2:0]  cfg;

	// decode from the current register contents; one cycle to outputs
	always_comb begin
		cfg      = global_q[2:0];
		fn_a_raw = decode_mode(a_mode_q[3:0]);
		fn_b_raw = decode_mode(b_mode_q[3:0]);
		joined_d = !cfg[2];
		// a half with no legal function stays idle
		fn_a_d   = TMC_FN_OFF;
		fn_b_d   = TMC_FN_OFF;
		// bit 2 of the global field alone marks the split configuration
		if (cfg[2]) begin
			fn_a_d = fn_a_raw;
			fn_b_d = fn_b_raw;
		end else if (cfg == TMC_CFG_RTC) begin
			fn_a_d = TMC_FN_RTC;
		end else if (cfg == TMC_CFG_JOINED) begin
			// only one-shot or periodic make sense joined; B is ignored
			if (fn_a_raw == TMC_FN_ONESHOT || fn_a_raw == TMC_FN_PERIODIC) begin
				fn_a_d = fn_a_raw;
			end
		end
		// reserved global codes 2 and 3 leave both halves idle
		edge_a_d = clean_edge(ctrl_q[TMC_BIT_EDGE_LO +: 2]);
		edge_b_d = clean_edge(ctrl_q[TMC_BIT_EDGE_LO + TMC_B_SHIFT +: 2]);
		flags_d  = {ctrl_q[TMC_BIT_INVERT], ctrl_q[TMC_BIT_INVERT + TMC_B_SHIFT],
			ctrl_q[TMC_BIT_TRIG], ctrl_q[TMC_BIT_TRIG + TMC_B_SHIFT],
			ctrl_q[TMC_BIT_STALL], ctrl_q[TMC_BIT_STALL + TMC_B_SHIFT]};
		// an enable only reaches a half that has a real function to run
		en_d = {ctrl_q[TMC_BIT_ENABLE] && fn_a_d != TMC_FN_OFF,
			ctrl_q[TMC_BIT_ENABLE + TMC_B_SHIFT] && fn_b_d != TMC_FN_OFF,
			ctrl_q[TMC_BIT_RTC_EN] && cfg == TMC_CFG_RTC};
	end

	// decoded outputs are registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			joined_q <= 1'b1; // global zero means joined
			fn_a_q   <= TMC_FN_OFF;
			fn_b_q   <= TMC_FN_OFF;
			edge_a_q <= 2'h0;
			edge_b_q <= 2'h0;
			flags_q  <= 6'h00;
			en_q     <= 3'h0;
		end else begin
			joined_q <= joined_d;
			fn_a_q   <= fn_a_d;
			fn_b_q   <= fn_b_d;
			edge_a_q <= edge_a_d;
			edge_b_q <= edge_b_d;
			flags_q  <= flags_d;
			en_q     <= en_d;
		end
	end

	// ----------------------------------------------------------------
	// decoded outputs
	// ----------------------------------------------------------------
	// the counting datapath sees only flops, never the raw register words
	assign joined_32             = joined_q;
	assign half_a_function       = fn_a_q;
	assign half_b_function       = fn_b_q;
	assign half_a_edge_select    = edge_a_q;
	assign half_b_edge_select    = edge_b_q;
	assign half_a_output_invert  = flags_q[5];
	assign half_b_output_invert  = flags_q[4];
	assign half_a_trigger_enable = flags_q[3];
	assign half_b_trigger_enable = flags_q[2];
	assign half_a_stall_enable   = flags_q[1];
	assign half_b_stall_enable   = flags_q[0];
	assign half_a_enable         = en_q[2];
	assign half_b_enable         = en_q[1];
	assign clock_count_enable    = en_q[0];

endmodule // tmc_regs

// ===== tmc_regs_asserts.sv
// Purpose: concurrent checks on the timer mode and control register block
// Assumes: one clock, synchronous active-low reset
// Notes:   watches the read channel and the decoded outputs only
`timescale 1ns/1ps
module tmc_regs_asserts
	import tmc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// read channel
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	// decoded controls
	input  wire logic        joined_32,
	input  wire tmc_fn_t     half_a_function,
	input  wire tmc_fn_t     half_b_function,
	input  wire logic [1:0]  half_a_edge_select,
	input  wire logic [1:0]  half_b_edge_select,
	input  wire logic        half_a_enable,
	input  wire logic        half_b_enable,
	input  wire logic        clock_count_enable
);
	// ------------------------------------------------------------
	// relations between decoded outputs, and reserved read bits
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_reset_quiet: assert property ($rose(aresetn) |-> joined_32 && !half_a_enable
		&& !half_b_enable && !clock_count_enable && half_a_function == TMC_FN_OFF)
		else $error("decoded outputs not idle after reset");
	chk_rtc_gate: assert property (clock_count_enable |-> half_a_function == TMC_FN_RTC)
		else $error("clock count enabled outside clock mode");
	chk_a_enable: assert property (half_a_enable |-> half_a_function != TMC_FN_OFF)
		else $error("half a enabled without a function");
	chk_b_enable: assert property (half_b_enable |-> half_b_function != TMC_FN_OFF)
		else $error("half b enabled without a function");
	chk_a_edge: assert property (half_a_edge_select != TMC_EDGE_RESV)
		else $error("half a shows reserved edge code");
	chk_b_edge: assert property (half_b_edge_select != TMC_EDGE_RESV)
		else $error("half b shows reserved edge code");
	chk_a_split: assert property (half_a_function inside {TMC_FN_EDGE_COUNT,
		TMC_FN_EDGE_TIME, TMC_FN_PWM} |-> !joined_32)
		else $error("half a capture or pwm while joined");
	chk_b_ignored: assert property (half_b_function != TMC_FN_OFF |-> !joined_32)
		else $error("half b active while joined");
	chk_rsvd_zero: assert property (s_axi_rvalid && s_axi_rresp == TMC_RESP_OKAY
		|-> (s_axi_rdata & ~TMC_CTRL_MASK) == 32'h0)
		else $error("reserved read bits not zero");
endmodule // tmc_regs_asserts

bind tmc_regs tmc_regs_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.joined_32(joined_32), .half_a_function(half_a_function),
	.half_b_function(half_b_function), .half_a_edge_select(half_a_edge_select),
	.half_b_edge_select(half_b_edge_select), .half_a_enable(half_a_enable),
	.half_b_enable(half_b_enable), .clock_count_enable(clock_count_enable));
